// ===== hdl/sbl_loader.sv
// serial boot command interpreter: autobaud, baud change, command dispatch
// assumes a back end that does flash, RAM, password and checksum work
`timescale 1ns/100ps
`default_nettype none
module sbl_loader (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // serial link pins
  input wire logic RXD,
  output logic TXD,
  // flash condition
  input wire logic PROTECTED,
  input wire logic BLANK,
  // operation requests and received data to the back end
  output sbl_pkg::sbl_fwd_s FWD,
  output sbl_pkg::sbl_op_s OP,
  output logic [3:0] INFO_IDX,
  output logic JUMP,
  output logic HALTED,
  // results from the back end
  input wire sbl_pkg::sbl_pwd_s PWD,
  input wire sbl_pkg::sbl_done_s DONE,
  input wire logic [7:0] INFO_BYTE
);
  import sbl_pkg::*;

  typedef enum logic [14:0] {
    M_MATCH = 15'h0001,
    M_SEND = 15'h0002,
    M_BAUD = 15'h0004,
    M_BSW = 15'h0008,
    M_CMD = 15'h0010,
    M_ADDR = 15'h0020,
    M_PWD = 15'h0040,
    M_AREA = 15'h0080,
    M_XFER = 15'h0100,
    M_SUM = 15'h0200,
    M_INFO = 15'h0400,
    M_ERR = 15'h0800,
    M_JMP = 15'h1000,
    M_HALT = 15'h2000,
    M_RUN = 15'h4000
  } sbl_state_e;

  sbl_state_e st_reg, st_next, ret_reg, ret_next, cmd_ret, pass_ret;
  logic [15:0] div_reg, div_next, ndiv_reg, ndiv_next;
  logic [15:0] sum_reg, sum_next, period;
  logic [7:0] txb_reg, txb_next, code_reg, code_next;
  logic [7:0] err_reg, err_next, rx_err, op_code, tx_data;
  logic [3:0] cnt_reg, cnt_next, info_len;
  logic [16:0] baud_lu;
  sbl_rx_s rx;
  logic rx_ok, rx_bad, cmd_known, pass_now, area_ok, tx_ready, tx_go;

  // receive path decode
  assign rx_ok = rx.valid & ~rx.ferr;
  assign rx_bad = rx.ferr | ~tx_ready; // a byte during our own reply is an overrun
  assign rx_err = rx.ferr ? ERR_FRAME : ERR_OVER;
  assign baud_lu = baud_div(rx.data);
  assign cmd_known = (rx.data == CMD_ERASE) || (rx.data == CMD_WRITE) ||
    (rx.data == CMD_RAM) || (rx.data == CMD_SUM) || (rx.data == CMD_ID) ||
    (rx.data == CMD_STAT) || (rx.data == CMD_PROT);

  // where a command goes once its echo is out
  assign cmd_ret = (rx.data == CMD_ERASE) ? M_ADDR :
    (rx.data == CMD_WRITE || rx.data == CMD_RAM) ?
      (PROTECTED ? M_HALT : M_ADDR) :
    (rx.data == CMD_SUM) ? M_XFER :
    (rx.data == CMD_PROT) ? M_CMD : M_INFO;
  assign pass_ret = (code_reg == CMD_ERASE) ? M_AREA : M_XFER;
  assign info_len = (code_reg == CMD_ID) ? ID_LEN : STAT_LEN;

  // password gate: blank parts pass after the four address bytes
  assign pass_now = (st_reg == M_ADDR && rx_ok && cnt_reg == ADDR_LEN - 4'h1 &&
    BLANK) || (st_reg == M_PWD && PWD.done && PWD.ok);
  assign area_ok = rx_ok && (!PROTECTED || rx.data == CHIP_AREA);

  // operation request to the back end
  assign op_code = (st_reg == M_CMD) ? rx.data : code_reg;
  assign OP.start = (st_reg == M_CMD && rx.valid && !rx_bad &&
    (rx.data == CMD_SUM || rx.data == CMD_PROT)) ||
    (pass_now && code_reg != CMD_ERASE) ||
    (st_reg == M_AREA && area_ok);
  assign OP.code = op_code;
  assign OP.area = rx.data;
  // erase range comes from the area nibbles, each one a 4-kbyte sector
  assign OP.lo = (op_code == CMD_ERASE) ? {rx.data[7:4], SECTOR_LO} :
    (op_code == CMD_RAM) ? RAM_LO : FLASH_LO;
  assign OP.hi = (op_code == CMD_ERASE) ? {rx.data[3:0], SECTOR_HI} :
    (op_code == CMD_RAM) ? RAM_HI : FLASH_HI;

  // addresses, password string and records stream to the back end
  assign FWD.valid = rx_ok && (st_reg == M_ADDR || st_reg == M_PWD ||
    st_reg == M_XFER);
  assign FWD.data = rx.data;

  // transmit selection
  assign tx_go = tx_ready && (st_reg == M_SEND || st_reg == M_SUM ||
    st_reg == M_INFO || st_reg == M_ERR);
  assign tx_data = (st_reg == M_SUM) ?
      ((cnt_reg == 4'h0) ? sum_reg[15:8] : sum_reg[7:0]) :
    (st_reg == M_INFO) ? INFO_BYTE :
    (st_reg == M_ERR) ? err_reg : txb_reg;
  assign INFO_IDX = cnt_reg;
  assign JUMP = (st_reg == M_JMP) && tx_ready;
  assign HALTED = (st_reg == M_HALT);

  // command sequencer
  always_comb begin
    st_next = st_reg;
    ret_next = ret_reg;
    div_next = div_reg;
    ndiv_next = ndiv_reg;
    sum_next = sum_reg;
    txb_next = txb_reg;
    code_next = code_reg;
    err_next = err_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      // hunt at the bit time measured from the match byte; a bad match stays silent
      M_MATCH: if (rx_ok && rx.data == CMD_MATCH) begin
        div_next = period;
        txb_next = CMD_MATCH;
        ret_next = M_BAUD;
        st_next = M_SEND;
      end
      M_SEND: if (tx_ready) begin
        st_next = ret_reg;
      end
      M_BAUD: if (rx.valid && rx_bad) begin
        err_next = rx_err;
        cnt_next = 4'h0;
        st_next = M_ERR;
      end else if (rx.valid && !baud_lu[16]) begin
        err_next = ERR_BAUD;
        cnt_next = 4'h0;
        st_next = M_ERR;
      end else if (rx.valid) begin
        txb_next = rx.data;
        ndiv_next = baud_lu[15:0];
        ret_next = M_BSW;
        st_next = M_SEND;
      end
      // switch rate only once the echo has left at the old one
      M_BSW: if (tx_ready) begin
        div_next = ndiv_reg;
        st_next = M_CMD;
      end
      M_CMD: if (rx.valid && rx_bad) begin
        err_next = rx_err;
        cnt_next = 4'h0;
        st_next = M_ERR;
      end else if (rx.valid && !cmd_known) begin
        err_next = ERR_CMD;
        cnt_next = 4'h0;
        st_next = M_ERR;
      end else if (rx.valid) begin
        txb_next = rx.data;
        code_next = rx.data;
        cnt_next = 4'h0;
        ret_next = cmd_ret;
        st_next = M_SEND;
      end
      // two address words, high byte first; a framing error halts
      M_ADDR: if (rx.valid && rx.ferr) begin
        st_next = M_HALT;
      end else if (rx.valid && cnt_reg == ADDR_LEN - 4'h1) begin
        cnt_next = 4'h0;
        st_next = BLANK ? pass_ret : M_PWD;
      end else if (rx.valid) begin
        cnt_next = cnt_reg + 4'h1;
      end
      M_PWD: if (PWD.done) begin
        st_next = PWD.ok ? pass_ret : M_HALT;
      end else if (rx.valid && rx.ferr) begin
        st_next = M_HALT;
      end
      M_AREA: if (rx.valid) begin
        st_next = area_ok ? M_XFER : M_HALT;
      end
      // a failed operation sends nothing and stops
      M_XFER: if (DONE.done) begin
        sum_next = DONE.sum;
        cnt_next = 4'h0;
        st_next = DONE.ok ? M_SUM : M_HALT;
      end
      M_SUM: if (tx_ready) begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'h1) begin
          st_next = (code_reg == CMD_RAM) ? M_JMP : M_CMD;
        end
      end
      M_INFO: if (tx_ready) begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == info_len - 4'h1) begin
          st_next = M_CMD;
        end
      end
      M_ERR: if (tx_ready) begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == ERR_REPEAT - 4'h1) begin
          st_next = M_HALT;
        end
      end
      M_JMP: if (tx_ready) begin
        st_next = M_RUN;
      end
      M_HALT, M_RUN: st_next = st_reg;
      default: st_next = M_HALT;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= M_MATCH;
      ret_reg <= M_MATCH;
      div_reg <= DIV_DEFAULT;
      ndiv_reg <= DIV_DEFAULT;
      sum_reg <= 16'h0000;
      txb_reg <= 8'h00;
      code_reg <= 8'h00;
      err_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      ret_reg <= ret_next;
      div_reg <= div_next;
      ndiv_reg <= ndiv_next;
      sum_reg <= sum_next;
      txb_reg <= txb_next;
      code_reg <= code_next;
      err_reg <= err_next;
      cnt_reg <= cnt_next;
    end
  end

  // receiver hunts for the start-bit length until matched
  sbl_uart_rx u_rx (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .rxd(RXD),
    .hunt(st_reg == M_MATCH),
    .div(div_reg),
    .rx(rx),
    .period(period)
  );

  sbl_uart_tx u_tx (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .start(tx_go),
    .data(tx_data),
    .div(div_reg),
    .ready(tx_ready),
    .txd(TXD)
  );

  // protocol checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  property p_setup_first;
    OP.start |-> (st_reg == M_CMD || st_reg == M_ADDR || st_reg == M_PWD ||
      st_reg == M_AREA);
  endproperty
  a_setup_first: assert property (p_setup_first)
    else $error("operation started before setup");

  property p_echo_match;
    (st_reg == M_MATCH && rx_ok && rx.data == CMD_MATCH) |=>
      (st_reg == M_SEND && tx_data == CMD_MATCH && div_reg == $past(period));
  endproperty
  a_echo_match: assert property (p_echo_match)
    else $error("match byte not echoed at measured rate");

  property p_write_prot;
    (OP.start && (OP.code == CMD_WRITE || OP.code == CMD_RAM)) |-> !PROTECTED;
  endproperty
  a_write_prot: assert property (p_write_prot)
    else $error("write or RAM load started while protected");

  property p_sector_prot;
    (OP.start && OP.code == CMD_ERASE && PROTECTED) |-> OP.area == CHIP_AREA;
  endproperty
  a_sector_prot: assert property (p_sector_prot)
    else $error("sector erase started while protected");

  property p_password;
    (OP.start && OP.code != CMD_SUM && OP.code != CMD_PROT) |->
      (pass_now || st_reg == M_AREA);
  endproperty
  a_password: assert property (p_password)
    else $error("operation started without password pass");

  property p_halt_stays;
    HALTED |=> (HALTED && !tx_go && !OP.start);
  endproperty
  a_halt_stays: assert property (p_halt_stays)
    else $error("left halt or talked while halted");

  property p_err_three;
    (st_reg == M_ERR && tx_go && cnt_reg == 4'h2) |=> HALTED;
  endproperty
  a_err_three: assert property (p_err_three)
    else $error("halt not entered after third error code");

  property p_sum_order;
    (st_reg == M_SUM && tx_go && cnt_reg == 4'h0) |->
      (tx_data == sum_reg[15:8]) ##1 (st_reg == M_SUM && $stable(sum_reg));
  endproperty
  a_sum_order: assert property (p_sum_order)
    else $error("checksum high byte not sent first");

  property p_back_to_cmd;
    (st_reg == M_SUM && tx_go && cnt_reg == 4'h1 && code_reg != CMD_RAM) |=>
      st_reg == M_CMD;
  endproperty
  a_back_to_cmd: assert property (p_back_to_cmd)
    else $error("no return to command wait after checksum");

  property p_jump_once;
    JUMP |-> (code_reg == CMD_RAM) ##1 (st_reg == M_RUN && !JUMP);
  endproperty
  a_jump_once: assert property (p_jump_once)
    else $error("jump without RAM load or repeated");

endmodule : sbl_loader
`default_nettype wire

// ===== hdl/sbl_uart_rx.sv
// serial receiver, 8N1, with start-bit length measurement for autobaud
// assumes an idle-high line; in hunt mode the byte must begin 0,0,1
`timescale 1ns/100ps
`default_nettype none
module sbl_uart_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // line and timing
  input wire logic rxd,
  input wire logic hunt,
  input wire logic [15:0] div,
  // received character and measured bit time
  output sbl_pkg::sbl_rx_s rx,
  output logic [15:0] period
);
  import sbl_pkg::*;

  typedef enum logic [3:0] {
    R_IDLE = 4'h1,
    R_MEAS = 4'h2,
    R_BITS = 4'h4,
    R_STOP = 4'h8
  } sbl_rx_state_e;

  sbl_rx_state_e st_reg, st_next;
  logic [2:0] sync_reg;
  logic line_reg, line_next, fall;
  logic [15:0] tmr_reg, tmr_next, per_reg, per_next, bit_time;
  logic [7:0] sh_reg, sh_next;
  logic [2:0] idx_reg, idx_next;
  sbl_rx_s rx_next;

  // a level counts once the second and third stages agree
  assign line_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_reg;
  assign fall = line_reg & ~line_next;
  assign bit_time = hunt ? per_reg : div;
  assign period = per_reg;

  // frame walk: start bit, 8 data bits lsb first, one stop bit
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    per_next = per_reg;
    sh_next = sh_reg;
    idx_next = idx_reg;
    rx_next = '0;
    unique case (st_reg)
      R_IDLE: if (fall) begin
        st_next = hunt ? R_MEAS : R_BITS;
        tmr_next = hunt ? 16'h0000 : div + (div >> 1);
        idx_next = 3'h0;
        sh_next = 8'h00;
      end
      // start plus bit 0 form one low run of two bit times
      R_MEAS: if (line_next) begin
        per_next = tmr_reg >> 1;
        tmr_next = tmr_reg >> 2;
        idx_next = 3'h1;
        st_next = R_BITS;
      end else if (tmr_reg == 16'hFFFF) begin
        st_next = R_IDLE;
      end else begin
        tmr_next = tmr_reg + 16'h0001;
      end
      R_BITS: if (tmr_reg == 16'h0000) begin
        sh_next = {line_reg, sh_reg[7:1]};
        tmr_next = bit_time - 16'h0001;
        idx_next = idx_reg + 3'h1;
        if (idx_reg == 3'h7) begin
          st_next = R_STOP;
        end
      end else begin
        tmr_next = tmr_reg - 16'h0001;
      end
      R_STOP: if (tmr_reg == 16'h0000) begin
        rx_next.valid = 1'b1;
        rx_next.data = sh_reg;
        rx_next.ferr = ~line_reg;
        st_next = R_IDLE;
      end else begin
        tmr_next = tmr_reg - 16'h0001;
      end
      default: st_next = R_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= R_IDLE;
      sync_reg <= 3'h7;
      line_reg <= 1'b1;
      tmr_reg <= 16'h0000;
      per_reg <= DIV_DEFAULT;
      sh_reg <= 8'h00;
      idx_reg <= 3'h0;
      rx <= '0;
    end else begin
      st_reg <= st_next;
      sync_reg <= {sync_reg[1:0], rxd};
      line_reg <= line_next;
      tmr_reg <= tmr_next;
      per_reg <= per_next;
      sh_reg <= sh_next;
      idx_reg <= idx_next;
      rx <= rx_next;
    end
  end

endmodule : sbl_uart_rx
`default_nettype wire

// ===== hdl/sbl_uart_tx.sv
// serial transmitter, 8N1, bit time given in clocks
// assumes div stays constant while a frame is on the line
`timescale 1ns/100ps
`default_nettype none
module sbl_uart_tx (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // byte to send
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic [15:0] div,
  // line and handshake
  output logic ready,
  output logic txd
);
  import sbl_pkg::*;

  logic [9:0] sh_reg;
  logic [3:0] cnt_reg;
  logic [15:0] tmr_reg;

  assign ready = (cnt_reg == 4'h0);
  assign txd = sh_reg[0];

  // stop bit is the idle level, so the line never glitches between frames
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_reg <= 10'h3FF;
      cnt_reg <= 4'h0;
      tmr_reg <= 16'h0000;
    end else if (start && ready) begin
      sh_reg <= {1'b1, data, 1'b0};
      cnt_reg <= FRAME_BITS;
      tmr_reg <= div - 16'h0001;
    end else if (!ready && tmr_reg == 16'h0000) begin
      sh_reg <= {1'b1, sh_reg[9:1]};
      cnt_reg <= cnt_reg - 4'h1;
      tmr_reg <= div - 16'h0001;
    end else if (!ready) begin
      tmr_reg <= tmr_reg - 16'h0001;
    end
  end

endmodule : sbl_uart_tx
`default_nettype wire

// ===== shared/sbl_pkg.sv
// constants, types and baud lookup for the serial boot command loader
// assumes a single 25 MHz system clock shared by all loader modules
package sbl_pkg;

  // clock and default link rate
  localparam int CLK_HZ = 25_000_000;
  localparam int BPS_DEFAULT = 9600;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BPS_DEFAULT);
  localparam logic [3:0] FRAME_BITS = 4'hA;

  // command bytes
  localparam logic [7:0] CMD_MATCH = 8'h5A;
  localparam logic [7:0] CMD_ERASE = 8'hF0;
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] CMD_RAM = 8'h60;
  localparam logic [7:0] CMD_SUM = 8'h90;
  localparam logic [7:0] CMD_ID = 8'hC0;
  localparam logic [7:0] CMD_STAT = 8'hC3;
  localparam logic [7:0] CMD_PROT = 8'hFA;

  // error codes and reply lengths
  localparam logic [7:0] ERR_FRAME = 8'hA1;
  localparam logic [7:0] ERR_OVER = 8'hA3;
  localparam logic [7:0] ERR_BAUD = 8'h62;
  localparam logic [7:0] ERR_CMD = 8'h63;
  localparam logic [3:0] ERR_REPEAT = 4'h3;
  localparam logic [3:0] ID_LEN = 4'hD;
  localparam logic [3:0] STAT_LEN = 4'h7;
  localparam logic [3:0] ADDR_LEN = 4'h4;

  // address ranges and erase area coding
  localparam logic [15:0] FLASH_LO = 16'h1000;
  localparam logic [15:0] FLASH_HI = 16'hFFFF;
  localparam logic [15:0] RAM_LO = 16'h0050;
  localparam logic [15:0] RAM_HI = 16'h083F;
  localparam logic [11:0] SECTOR_LO = 12'h000;
  localparam logic [11:0] SECTOR_HI = 12'hFFF;
  localparam logic [7:0] CHIP_AREA = 8'h1F;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic ferr;
  } sbl_rx_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sbl_fwd_s;

  typedef struct packed {
    logic start;
    logic [7:0] code;
    logic [7:0] area;
    logic [15:0] lo;
    logic [15:0] hi;
  } sbl_op_s;

  typedef struct packed {
    logic done;
    logic ok;
  } sbl_pwd_s;

  typedef struct packed {
    logic done;
    logic ok;
    logic [15:0] sum;
  } sbl_done_s;

  // baud change byte to {valid, bit time in clocks}
  function automatic logic [16:0] baud_div(input logic [7:0] code);
    case (code)
      8'h04: baud_div = {1'b1, 16'(CLK_HZ / 76800)};
      8'h05: baud_div = {1'b1, 16'(CLK_HZ / 62500)};
      8'h06: baud_div = {1'b1, 16'(CLK_HZ / 57600)};
      8'h07: baud_div = {1'b1, 16'(CLK_HZ / 38400)};
      8'h0A: baud_div = {1'b1, 16'(CLK_HZ / 31250)};
      8'h18: baud_div = {1'b1, 16'(CLK_HZ / 19200)};
      8'h28: baud_div = {1'b1, DIV_DEFAULT};
      default: baud_div = 17'h00000;
    endcase
  endfunction : baud_div

endpackage : sbl_pkg

// ===== verification/sbl_ctl_model.sv
// behavioural write controller: sends and receives 8N1 characters
// assumes the bench calls its tasks; the line rests high between frames
`timescale 1ns/100ps
`default_nettype none
module sbl_ctl_model (
  // clock
  input wire logic clk,
  // serial pins, seen from the controller
  output logic tx_line,
  input wire logic rx_line
);
  initial tx_line = 1'b1;

  // start bit, eight data bits lsb first, one stop bit, no parity
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_line = f[i];
      repeat (bt) @(negedge clk);
    end
  endtask : send

  // sample at bit centres; ok stays low on silence or a bad stop bit
  task automatic recv(output logic [7:0] b, output logic ok, input int bt, input int wmax);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (rx_line !== 1'b0 && n < wmax) begin
      @(negedge clk);
      n++;
    end
    if (n < wmax) begin
      repeat (bt / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(negedge clk);
        b[i] = rx_line;
      end
      repeat (bt) @(negedge clk);
      ok = (rx_line === 1'b1);
    end
  endtask : recv
endmodule : sbl_ctl_model
`default_nettype wire

// ===== verification/tb_serial_boot_command_loader.sv
// self-checking bench for the serial boot command loader
// assumes the controller model on the link; the bench plays the back end
`timescale 1ns/100ps
`default_nettype none
module tb_serial_boot_command_loader;
  import sbl_pkg::*;
  // short match bit time keeps the run brief; 04H then selects 76800 bps
  localparam int BT0 = 50;
  localparam int BT1 = CLK_HZ / 76800;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic RXD;
  logic TXD;
  logic PROTECTED = 1'b0;
  logic BLANK = 1'b1;
  logic JUMP;
  logic HALTED;
  logic [3:0] INFO_IDX;
  sbl_fwd_s FWD;
  sbl_op_s OP;
  sbl_op_s op_last;
  sbl_pwd_s PWD = '0;
  sbl_done_s DONE = '0;
  int op_cnt = 0;
  int cyc = 0;
  int error_cnt = 0;
  int checked = 0;
  int fwd_cnt = 0;
  int jmp_cnt = 0;
  logic [7:0] fwd_last = 8'h00;
  // block bytes follow the index, so their order and count are visible
  wire [7:0] info_byte = {4'hA, INFO_IDX};

  always #20 SYS_CLK = ~SYS_CLK;

  sbl_loader dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .RXD(RXD), .TXD(TXD),
    .PROTECTED(PROTECTED), .BLANK(BLANK), .FWD(FWD), .OP(OP), .INFO_IDX(INFO_IDX),
    .JUMP(JUMP), .HALTED(HALTED), .PWD(PWD), .DONE(DONE), .INFO_BYTE(info_byte));
  sbl_ctl_model ctl (.clk(SYS_CLK), .tx_line(RXD), .rx_line(TXD));

  // requests last one cycle, so catch them here; a hang ends the run
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (OP.start === 1'b1) begin
      op_last <= OP;
      op_cnt <= op_cnt + 1;
    end
    if (FWD.valid === 1'b1) begin
      fwd_last <= FWD.data;
      fwd_cnt <= fwd_cnt + 1;
    end
    if (JUMP === 1'b1) begin
      jmp_cnt <= jmp_cnt + 1;
    end
    // the command phase runs at 325 clocks a bit, so the full run needs about 126k cycles
    if (cyc == 140000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic get(input logic [7:0] e, input int bt);
    logic [7:0] r;
    logic ok;
    ctl.recv(r, ok, bt, 40 * bt);
    check({ok, r}, {1'b1, e}, "reply");
  endtask : get

  task automatic quiet(input int w);
    logic [7:0] r;
    logic ok;
    ctl.recv(r, ok, BT1, w);
    check(ok, 1'b0, "silence");
  endtask : quiet

  // returns at the echo's stop-bit centre, so a block that follows the echo at once is caught
  task automatic xchg(input logic [7:0] s, input logic [7:0] e, input int bt);
    fork
      ctl.send(s, bt);
      get(e, bt);
    join
  endtask : xchg

  task automatic bad(input logic [7:0] s, input logic [7:0] e, input int bt);
    fork
      ctl.send(s, bt);
      repeat (3) get(e, bt);
    join
    repeat (2 * bt) @(negedge SYS_CLK);
    check(HALTED, 1'b1, "halt");
  endtask : bad

  task automatic reset_dut();
    RSTN = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    RSTN = 1'b1;
    repeat (4) @(negedge SYS_CLK);
  endtask : reset_dut

  task automatic setup();
    reset_dut();
    xchg(CMD_MATCH, CMD_MATCH, BT0);
    xchg(8'h04, 8'h04, BT0);
    // the rate switches only once the echo's stop bit is out
    repeat (BT0) @(negedge SYS_CLK);
  endtask : setup

  task automatic finish_op(input logic [15:0] s);
    DONE = '{done: 1'b1, ok: 1'b1, sum: s};
    @(negedge SYS_CLK);
    DONE = '0;
    get(s[15:8], BT1);
    get(s[7:0], BT1);
  endtask : finish_op

  task automatic t_ops();
    int n;
    setup();
    xchg(CMD_SUM, CMD_SUM, BT1);
    check(op_last.code, CMD_SUM, "sum op");
    finish_op(16'hC35A);
    xchg(CMD_PROT, CMD_PROT, BT1);
    check(op_last.code, CMD_PROT, "protect op");
    PROTECTED = 1'b1;
    xchg(CMD_ERASE, CMD_ERASE, BT1);
    n = fwd_cnt;
    for (int i = 0; i < 4; i++) ctl.send(8'(16 + i), BT1);
    ctl.send(CHIP_AREA, BT1);
    check({8'(fwd_cnt - n), fwd_last}, 16'h0413, "forwarded");
    check({op_last.code, op_last.area, op_last.lo, op_last.hi}, 48'hF01F1000FFFF, "erase");
    finish_op(16'h0FF0);
    xchg(CMD_STAT, CMD_STAT, BT1);
    for (int i = 0; i < 7; i++) get({4'hA, 4'(i)}, BT1);
    quiet(3 * BT1);
    check(8'(jmp_cnt), 8'h00, "no jump after checksum");
    bad(8'h55, ERR_CMD, BT1);
    $display("test of command set done");
  endtask : t_ops

  task automatic t_baud();
    reset_dut();
    fork
      ctl.send(8'hB2, BT0);
      quiet(14 * BT0);
    join
    xchg(CMD_MATCH, CMD_MATCH, BT0);
    bad(8'h33, ERR_BAUD, BT0);
    $display("test of baud errors done");
  endtask : t_baud

  task automatic t_prot();
    int n;
    PROTECTED = 1'b1;
    setup();
    n = op_cnt;
    xchg(CMD_WRITE, CMD_WRITE, BT1);
    repeat (4) @(negedge SYS_CLK);
    check({HALTED, 8'(op_cnt - n)}, 9'h100, "write refused");
    $display("test of protected write done");
  endtask : t_prot

  task automatic t_pwd();
    int n;
    PROTECTED = 1'b0;
    BLANK = 1'b0;
    setup();
    n = op_cnt;
    xchg(CMD_RAM, CMD_RAM, BT1);
    // the back end rejects the address pair before any string arrives
    for (int i = 0; i < 4; i++) ctl.send(8'(32 + i), BT1);
    PWD = '{done: 1'b1, ok: 1'b0};
    @(negedge SYS_CLK);
    PWD = '0;
    repeat (4) @(negedge SYS_CLK);
    check({HALTED, 8'(op_cnt - n)}, 9'h100, "password refused");
    $display("test of password failure done");
  endtask : t_pwd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    t_ops();
    t_baud();
    t_prot();
    t_pwd();
    complete_run();
  end
endmodule : tb_serial_boot_command_loader
`default_nettype wire
